//--- common/gdio_pkg.sv
// Constants, reset values and the operation summary for the digital I/O port
// Summary of operation
// - Each pin has direction, output value, pull-up and input sample bits.
// - Direction one makes the pin an output; zero disables its driver.
// - An output pin drives the output value bit onto the pad.
// - Pull-up follows its enable bit in any direction; else input floats.
// - Reset tri-states every pin at the next clock edge; it is synchronous.
// - Writing one to an input sample bit inverts the output value bit.
// - Break-before-make holds a new output tri-stated for one cycle.
// - One port-wide bit enables break-before-make for all pins.
// - Output to input switching inserts no tri-state cycle.
// - Input sample is latch open while clock high, then a register.
// - A pad change shows in the sample bit after half to 1.5 periods.
// - A software driven value shows in the sample one period later.
// - In power-down and standby the digital input is clamped to ground.
// - The sleep clamp is bypassed for pins with external interrupt enabled.
// - A high pin released from the clamp gives an edge on wake.
// - Pull-ups are disabled while reset is active.
// - Four registers per port; input sample read-only, others read/write.
// - Single bits may change without disturbing other bits of the port.
package gdio_pkg;
  localparam int unsigned GDIO_WIDTH     = 8;
  localparam logic [7:0]  GDIO_DIR_RST   = 8'h00;
  localparam logic [7:0]  GDIO_OUT_RST   = 8'h00;
  localparam logic [7:0]  GDIO_PULL_RST  = 8'h00;
  localparam logic        GDIO_BBM_RST   = 1'b0;
  localparam int unsigned GDIO_BBM_CYC   = 1;
  localparam int unsigned GDIO_READ_LAT  = 1;
endpackage : gdio_pkg

//--- design/gdio_sync_bit.sv
// Input synchronizer for one pin: clock-high latch followed by a register
`timescale 1ns/10ps
`default_nettype none
module gdio_sync_bit (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pad_in,
  output var  logic sample_reg
);
  logic latch_q;
  logic sample_next;

  // The clock-high latch is taken as a falling-edge capture: the register
  // sees the same held value, with no race at the rising edge
  always_ff @(negedge sys_clk) begin
    latch_q <= pad_in;
  end

  always_comb begin
    sample_next = latch_q;
  end

  // Second stage reads only the latch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= sample_next;
    end
  end
endmodule : gdio_sync_bit
`default_nettype wire

//--- design/gdio_port.sv
// Eight-pin general digital I/O port with break-before-make and sleep clamp
`timescale 1ns/10ps
`default_nettype none
module gdio_port #(
  parameter int unsigned WIDTH = gdio_pkg::GDIO_WIDTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] dir_wr_mask,
  input  wire logic [WIDTH-1:0] dir_wr_data,
  input  wire logic [WIDTH-1:0] out_wr_mask,
  input  wire logic [WIDTH-1:0] out_wr_data,
  input  wire logic [WIDTH-1:0] pull_wr_mask,
  input  wire logic [WIDTH-1:0] pull_wr_data,
  input  wire logic [WIDTH-1:0] toggle_wr,
  input  wire logic             bbm_wr,
  input  wire logic             bbm_wr_data,
  input  wire logic             sleep_clamp,
  input  wire logic [WIDTH-1:0] ext_irq_enable,
  input  wire logic [WIDTH-1:0] pad_in,
  output var  logic [WIDTH-1:0] pad_out,
  output var  logic [WIDTH-1:0] pad_oe,
  output var  logic [WIDTH-1:0] pad_pullup,
  output var  logic [WIDTH-1:0] port_direction_register,
  output var  logic [WIDTH-1:0] port_output_value_register,
  output var  logic [WIDTH-1:0] port_pullup_register,
  output var  logic [WIDTH-1:0] port_input_sample_register,
  output var  logic             break_before_make_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [WIDTH-1:0] dir_next;
  logic [WIDTH-1:0] out_next;
  logic [WIDTH-1:0] pull_next;
  logic             bbm_next;

  always_comb begin
    // Masked writes touch only selected bits
    dir_next  = (port_direction_register & ~dir_wr_mask)
              | (dir_wr_data & dir_wr_mask);
    pull_next = (port_pullup_register & ~pull_wr_mask)
              | (pull_wr_data & pull_wr_mask);
    out_next  = (port_output_value_register & ~out_wr_mask)
              | (out_wr_data & out_wr_mask);
    // Toggle applies after a direct write, whatever the direction
    out_next  = out_next ^ toggle_wr;
    bbm_next  = bbm_wr ? bbm_wr_data : break_before_make_enable;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_direction_register    <= gdio_pkg::GDIO_DIR_RST;
      port_output_value_register <= gdio_pkg::GDIO_OUT_RST;
      port_pullup_register       <= gdio_pkg::GDIO_PULL_RST;
      break_before_make_enable   <= gdio_pkg::GDIO_BBM_RST;
    end else begin
      port_direction_register    <= dir_next;
      port_output_value_register <= out_next;
      port_pullup_register       <= pull_next;
      break_before_make_enable   <= bbm_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive
  // Registered pad controls keep outputs glitch free; they are built from the
  // next register values, so they change at the same edge except new outputs under break-before-make, and reset clears them synchronously
  logic [WIDTH-1:0] oe_next;
  logic [WIDTH-1:0] pout_next;
  logic [WIDTH-1:0] pup_next;
  logic [WIDTH-1:0] rising_dir;

  always_comb begin
    rising_dir = dir_next & ~port_direction_register;
    // New outputs wait one cycle under break-before-make
    // Falling direction bits release at once
    oe_next    = break_before_make_enable ? (dir_next & ~rising_dir)
                                          : dir_next;
    pout_next  = out_next;
    pup_next   = pull_next;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_oe     <= '0;
      pad_out    <= '0;
      pad_pullup <= '0;
    end else begin
      pad_oe     <= oe_next;
      pad_out    <= pout_next;
      pad_pullup <= pup_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input path
  // Pad level seen by the input: driven value wins, clamp applies in sleep
  logic [WIDTH-1:0] pad_level;
  logic [WIDTH-1:0] din;

  always_comb begin
    pad_level = (pad_oe & pad_out) | (~pad_oe & pad_in);
    // Clamp to ground unless external interrupt is enabled
    // Releasing the clamp on a high pin produces a rising edge
    din = pad_level & ~({WIDTH{sleep_clamp}} & ~ext_irq_enable);
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_sync
      gdio_sync_bit u_sync (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .pad_in     (din[gi]),
        .sample_reg (port_input_sample_register[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Reset values
  a_pins_reset: assert property (
    @(posedge sys_clk)
    rst |=>
    (pad_oe == '0 && pad_pullup == '0))
    else $error("pads not released by reset");

  a_pout_reset: assert property (
    @(posedge sys_clk)
    rst |=>
    pad_out == '0)
    else $error("pad value not cleared by reset");

  a_pull_reset: assert property (
    @(posedge sys_clk)
    rst |=>
    pad_pullup == '0)
    else $error("pull-up active during reset");

  a_regs_reset: assert property (
    @(posedge sys_clk)
    rst |=>
    (port_direction_register == '0 && !break_before_make_enable))
    else $error("control bits not zero after reset");

  a_outs_reset: assert property (
    @(posedge sys_clk)
    rst |=>
    (port_output_value_register == '0 && port_pullup_register == '0))
    else $error("value or pull-up bits not zero after reset");

  a_sample_reset: assert property (
    @(posedge sys_clk)
    rst |=>
    port_input_sample_register == '0)
    else $error("input sample not cleared by reset");

  //////////////////////////////////////////////////////////////////////////////
  // Register writes
  a_dir_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=>
    port_direction_register ==
      (($past(port_direction_register) & ~$past(dir_wr_mask))
       | ($past(dir_wr_data) & $past(dir_wr_mask))))
    else $error("direction write disturbed other bits");

  a_pull_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=>
    port_pullup_register ==
      (($past(port_pullup_register) & ~$past(pull_wr_mask))
       | ($past(pull_wr_data) & $past(pull_wr_mask))))
    else $error("pull-up write disturbed other bits");

  a_out_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    toggle_wr == '0 |=>
    port_output_value_register ==
      (($past(port_output_value_register) & ~$past(out_wr_mask))
       | ($past(out_wr_data) & $past(out_wr_mask))))
    else $error("output value write disturbed other bits");

  a_toggle_inv: assert property (
    @(posedge sys_clk) disable iff (rst)
    (toggle_wr != '0 && out_wr_mask == '0) |=>
    port_output_value_register ==
      ($past(port_output_value_register) ^ $past(toggle_wr)))
    else $error("toggle did not invert output value");

  a_out_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (toggle_wr == '0 && out_wr_mask == '0) |=>
    $stable(port_output_value_register))
    else $error("output value changed without a write");

  a_bbm_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    bbm_wr |=>
    break_before_make_enable == $past(bbm_wr_data))
    else $error("break-before-make enable not written");

  a_bbm_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !bbm_wr |=>
    $stable(break_before_make_enable))
    else $error("break-before-make enable changed alone");

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive
  a_bbm_gap: assert property (
    @(posedge sys_clk) disable iff (rst)
    (break_before_make_enable && (rising_dir != '0) && !bbm_wr) |=>
    ((pad_oe & $past(rising_dir)) == '0) ##1
    ((pad_oe & $past(rising_dir, 2)) == $past(rising_dir, 2)))
    else $error("break-before-make gap wrong");

  a_make_next: assert property (
    @(posedge sys_clk) disable iff (rst)
    (break_before_make_enable && (rising_dir != '0) && !bbm_wr) |=>
    ((port_direction_register & $past(rising_dir)) == $past(rising_dir)))
    else $error("direction not taken during the gap");

  a_bbm_steady: assert property (
    @(posedge sys_clk) disable iff (rst)
    (break_before_make_enable && !bbm_wr && rising_dir == '0) |=>
    pad_oe == $past(dir_next))
    else $error("gap inserted without a new output");

  a_no_gap: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!break_before_make_enable && !bbm_wr) |=>
    pad_oe == $past(dir_next))
    else $error("direction not applied in one cycle");

  a_oe_in_dir: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |->
    (pad_oe & ~port_direction_register) == '0)
    else $error("input pin still driven");

  a_release_now: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((port_direction_register & ~dir_next) != '0) |=>
    ((pad_oe & $past(port_direction_register & ~dir_next)) == '0))
    else $error("output to input delayed");

  a_drive_value: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 pad_out == $past(out_next))
    else $error("pad value not output register");

  a_drive_reg: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |->
    pad_out == port_output_value_register)
    else $error("pad value differs from output value bits");

  a_pullup_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 pad_pullup == $past(pull_next))
    else $error("pull-up not following enable");

  a_pull_reg: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |->
    pad_pullup == port_pullup_register)
    else $error("pull-up differs from enable bits");

  //////////////////////////////////////////////////////////////////////////////
  // Input path
  a_clamp_low: assert property (
    @(posedge sys_clk) disable iff (rst)
    (sleep_clamp && ext_irq_enable == '0) [*2] |=>
    port_input_sample_register == '0)
    else $error("clamped input not low");

  a_awake_pass: assert property (
    @(posedge sys_clk) disable iff (rst)
    !sleep_clamp |->
    din == pad_level)
    else $error("input blocked while awake");

  a_bypass: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |->
    (din & ext_irq_enable) == (pad_level & ext_irq_enable))
    else $error("clamp applied to interrupt pin");

  a_wake_pass: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(sleep_clamp) |->
    din == pad_level)
    else $error("clamp not released on wake");

  // Bits that held still over the last cycle must already be sampled
  a_sample_track: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) |->
    ((port_input_sample_register ^ din) & ~(din ^ $past(din))) == '0)
    else $error("input sample lags a steady pin");

  c_bbm_out: cover property (@(posedge sys_clk)
    break_before_make_enable && rising_dir != '0);
  c_toggle: cover property (@(posedge sys_clk) toggle_wr != '0);
  c_clamp_bypass: cover property (@(posedge sys_clk)
    sleep_clamp && ext_irq_enable != '0);
  c_wake: cover property (@(posedge sys_clk)
    $fell(sleep_clamp));
  c_release: cover property (@(posedge sys_clk)
    (port_direction_register & ~dir_next) != '0);

endmodule : gdio_port
`default_nettype wire

//--- tb/gdio_board.sv
// Board model: resolves each pad from driver, pull-up and outside source
`timescale 1ns/10ps
`default_nettype none
module gdio_board (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output var  logic [7:0] pad_in
);
  logic [7:0] float_pat = 8'h00;
  // Undriven pads wander every cycle so a stale level never passes
  always @(posedge sys_clk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_pat[i];
    end
  end
endmodule : gdio_board
`default_nettype wire

//--- tb/gdio_port_test.sv
// Self-checking bench for the digital I/O port
`timescale 1ns/10ps
`default_nettype none
module gdio_port_test;
  logic       sys_clk, rst, bbm_wr, bbm_wr_data, sleep_clamp, bbm_r;
  logic [7:0] dir_wr_mask, dir_wr_data, out_wr_mask, out_wr_data, toggle_wr;
  logic [7:0] pull_wr_mask, pull_wr_data, ext_irq_enable, ext_en, ext_val;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, dir_r, out_r, pull_r;
  logic [7:0] samp_r;
  int         n_mismatch = 0;
  int         compares = 0;
  gdio_port gdio_port_inst (.sys_clk(sys_clk), .rst(rst),
    .dir_wr_mask(dir_wr_mask), .dir_wr_data(dir_wr_data),
    .out_wr_mask(out_wr_mask), .out_wr_data(out_wr_data),
    .pull_wr_mask(pull_wr_mask), .pull_wr_data(pull_wr_data),
    .toggle_wr(toggle_wr), .bbm_wr(bbm_wr), .bbm_wr_data(bbm_wr_data),
    .sleep_clamp(sleep_clamp), .ext_irq_enable(ext_irq_enable),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .port_direction_register(dir_r),
    .port_output_value_register(out_r), .port_pullup_register(pull_r),
    .port_input_sample_register(samp_r), .break_before_make_enable(bbm_r));
  gdio_board gdio_board_inst (.sys_clk(sys_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // One write cycle, masks dropped at the following edge
  task wr(input logic [7:0] dm, dd, om, od, pm, pd, tg, input logic bw, bd);
    @(posedge sys_clk);
    {dir_wr_mask, dir_wr_data, out_wr_mask, out_wr_data} <= {dm, dd, om, od};
    {pull_wr_mask, pull_wr_data, toggle_wr} <= {pm, pd, tg};
    {bbm_wr, bbm_wr_data} <= {bw, bd};
    @(posedge sys_clk);
    {dir_wr_mask, out_wr_mask, pull_wr_mask, toggle_wr} <= 32'h0;
    bbm_wr <= 1'b0;
    #1;
  endtask : wr
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Watchdog cuts a hang short
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, bbm_wr, bbm_wr_data, sleep_clamp} = 4'h8;
    {dir_wr_mask, dir_wr_data, out_wr_mask, out_wr_data} = 32'h0;
    {pull_wr_mask, pull_wr_data, toggle_wr, ext_irq_enable} = 32'h0;
    {ext_en, ext_val} = 16'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("dir", 8'h00, dir_r);
    chk("out", 8'h00, out_r);
    chk("pull", 8'h00, pull_r);
    chk("bbm", 8'h00, {7'h00, bbm_r});
    chk("oe", 8'h00, pad_oe);
    wr(8'h03, 8'h03, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 0, 0);
    chk("oe", 8'h03, pad_oe);
    chk("drive", 8'h01, pad_out & 8'h03);
    wr(8'h04, 8'hff, 8'h0c, 8'hff, 8'h00, 8'h00, 8'h00, 0, 0);
    chk("dir", 8'h07, dir_r);
    chk("out", 8'h0d, out_r);
    tick(1);
    chk("readback", 8'h05, samp_r & 8'h07);
    wr(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 0, 0);
    chk("toggle", 8'h8c, out_r);
    wr(8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 0, 0);
    chk("toggle", 8'h8c, out_r);
    wr(8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hf0, 8'h00, 0, 0);
    chk("pullup", 8'hf0, pad_pullup);
    tick(1);
    chk("pulled", 8'h70, samp_r & 8'h70);
    @(posedge sys_clk);
    {ext_en, ext_val} <= 16'h2000;
    #1;
    chk("early", 8'h20, samp_r & 8'h20);
    tick(1);
    chk("late", 8'h00, samp_r & 8'h20);
    wr(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1, 1);
    chk("bbm", 8'h01, {7'h00, bbm_r});
    wr(8'h88, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0);
    chk("break", 8'h00, pad_oe & 8'h88);
    tick(1);
    chk("make", 8'h88, pad_oe & 8'h88);
    chk("pullup", 8'hf0, pad_pullup);
    wr(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0);
    chk("release", 8'h8e, pad_oe);
    @(posedge sys_clk);
    {sleep_clamp, ext_irq_enable} <= 9'h140;
    tick(2);
    chk("clamp", 8'h40, samp_r);
    @(posedge sys_clk);
    ext_irq_enable <= 8'h00;
    tick(2);
    chk("clamp", 8'h00, samp_r);
    @(posedge sys_clk);
    sleep_clamp <= 1'b0;
    #1;
    chk("asleep", 8'h00, samp_r);
    tick(1);
    chk("wake", 8'h40, samp_r & 8'h40);
    @(posedge sys_clk);
    {rst, sleep_clamp} <= 2'b10;
    tick(1);
    chk("oe", 8'h00, pad_oe);
    chk("pullup", 8'h00, pad_pullup);
    chk("dir", 8'h00, dir_r);
    @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    close_out();
  end
endmodule : gdio_port_test
`default_nettype wire
